// ===== hdl/tmc_store.sv
// Word store holding the PC word, EPC words and user words; every reset restores the factory values.
// Assumes the write path is already checked by the controller.
`default_nettype none
module tmc_store
   import tmc_pkg::*;
(
   input wire logic mclk_i,
   input wire logic arst_n_i,
   tmc_mem_if.store mem
);
   // Storage words; word zero starts at the factory PC value.
   logic [15:0] words_q [2**MEM_AW];

   // Write port; all words take their factory value at reset.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < 2**MEM_AW; i++) begin
            words_q[i] <= (i == 0) ? PC_RST : 16'h0000;
         end
      end else if (mem.we) begin
         words_q[mem.waddr] <= mem.wdata;
      end
   end

   // Read port with a register, so data trails the address by one cycle.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mem.rdata <= 16'h0000;
      end else begin
         mem.rdata <= words_q[mem.raddr];
      end
   end
endmodule : tmc_store
`default_nettype wire

// ===== hdl/tmc_top.sv
// Memory banks and configuration logic of a passive UHF tag.
// Assumes decoded reader commands on a valid/ready port and the analog tuning value as an input.
// Functional notes
// - Hold 32-bit access password, default zero.
// - Nonzero access password needed to become secured; the code also secures on an Access carrying the matching zero password.
// - Kill password at reserved start; kill silences.
// - Refuse kill when kill password zero.
// - Configuration bits change only when secured.
// - Configuration via single-word write to word 4.
// - Map bit starts one, changes once.
// - Map one: 128-bit EPC; zero: 64 user bits.
// - Map locks on selection or any Lock.
// - Short-range bit defaults zero, writable both ways.
// - Tuning disable forces zero capacitance change.
// - Read-only 3-bit tuning value, zero to four.
// - Tuning codes map to -80..+100 fF.
// - Tuning value read at reserved word 0Eh.
// - Locked reserved bank locks tuning disable.
// - Tuning readout need not match applied capacitance.
// - EPC bank: CRC, PC, EPC at 20h.
// - PC fields; factory value 3400 hex.
// - CRC16 computed over PC and EPC at power-up.
// - EPC bank selected by bank code 01.
// - EPC length adjustable within map limits.
// - TID flags extended identity, 48-bit serial.
`default_nettype none
module tmc_top
   import tmc_pkg::*;
#(
   parameter logic [15:0] TID_WORD0 = 16'hA5C1, // Class and maker code, arbitrary; bit 3, the extended identity flag, is set below.
   parameter logic [15:0] TID_MODEL = 16'h0123, // Model number, arbitrary.
   parameter logic [47:0] TID_SERIAL = 48'h0000_0000_0003 // Serial with even parity, arbitrary.
) (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic cmd_valid_i,
   input wire tmc_op_t cmd_op_i,
   input wire logic [1:0] cmd_bank_i,
   input wire logic [7:0] cmd_addr_i,
   input wire logic [7:0] cmd_wcnt_i,
   input wire logic [15:0] cmd_data_i,
   input wire logic [31:0] cmd_pwd_i,
   input wire logic [2:0] tune_value_i,
   output logic cmd_ready_o,
   output logic rsp_valid_o,
   output logic rsp_ok_o,
   output logic [15:0] rsp_data_o,
   output logic secured_o,
   output logic killed_o,
   output logic short_range_o,
   output logic mem_map_o,
   output logic [2:0] tune_code_o,
   output logic signed [7:0] tune_ff_o,
   output logic [15:0] epc_crc_o
);
   tmc_mem_if mem ();
   tmc_store u_store (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .mem(mem));

   tmc_state_t state_q, state_d; // Controller state.
   logic [31:0] kill_pwd_q; // Kill password.
   logic [31:0] acc_pwd_q; // Access password.
   logic map_q, short_q, tdis_q; // Configuration bits.
   logic map_locked_q; // Memory map can no longer change.
   logic res_locked_q; // Reserved bank is write locked.
   logic secured_q; // Reader has supplied the access password.
   logic killed_q; // Tag is permanently silent.
   logic [15:0] crc_q; // Running and final CRC.
   logic [3:0] idx_q; // Word index of the power-up CRC walk.
   logic [4:0] len_q; // EPC length taken from the PC word.
   logic rsp_valid_q, rsp_ok_q; // Registered answer.
   logic rsp_mem_q; // Answer data comes from the word store.
   logic [15:0] rsp_val_q; // Answer data from a register source.

   // Folds one 16-bit word into the CRC, MSB first.
   function automatic logic [15:0] crc_word(input logic [15:0] crc, input logic [15:0] w);
      logic [15:0] c;
      c = crc;
      for (int i = 15; i >= 0; i--) begin
         c = (c[15] ^ w[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : crc_word

   // Tuning code to capacitance change in fF.
   function automatic logic signed [7:0] tune_ff(input logic [2:0] code);
      case (code)
         3'h0: return -8'sd80;
         3'h1: return -8'sd40;
         3'h3: return 8'sd60;
         3'h4: return 8'sd100;
         default: return 8'sd0;
      endcase
   endfunction : tune_ff

   // Command decode, only meaningful in idle.
   logic take; // Command accepted this cycle.
   logic is_wr; // Write or single-word block write.
   logic ok; // Command will succeed.
   logic mem_rd, mem_wr; // Word store access.
   logic [3:0] midx; // Word store index.
   logic [15:0] rval; // Register-sourced read value.
   logic [4:0] epc_max; // EPC word limit of the active map.
   logic [7:0] user_max; // User word count of the active map.
   logic pwd_wr; // Password word write.
   logic cfg_wr; // Configuration word write.
   logic [7:0] epc_off; // EPC bank word offset from PC.
   logic [7:0] user_idx; // User word index.
   assign take = cmd_valid_i && cmd_ready_o;
   assign is_wr = (cmd_op_i == OP_WRITE) || (cmd_op_i == OP_BWRITE && cmd_wcnt_i == 8'h01);
   assign epc_max = map_q ? EPC_MAX_MAP1 : EPC_MAX_MAP0;
   assign user_max = map_q ? USER_WORDS_MAP1 : USER_WORDS_MAP0;
   assign epc_off = cmd_addr_i - EPC_PC_WORD;
   assign user_idx = cmd_addr_i + 8'(MEM_USER);

   // Bank and address decode; unmapped or write-protected words are refused.
   always_comb begin
      ok = 1'b0;
      mem_rd = 1'b0;
      mem_wr = 1'b0;
      midx = MEM_PC;
      rval = 16'h0000;
      pwd_wr = 1'b0;
      cfg_wr = 1'b0;
      if (cmd_op_i == OP_READ) begin
         if (cmd_bank_i == BANK_RES) begin
            if (cmd_addr_i <= RES_ACC_LO) begin
               ok = 1'b1;
               case (cmd_addr_i[1:0])
                  2'h0: rval = kill_pwd_q[31:16];
                  2'h1: rval = kill_pwd_q[15:0];
                  2'h2: rval = acc_pwd_q[31:16];
                  default: rval = acc_pwd_q[15:0];
               endcase
            end else if (cmd_addr_i == RES_CFG) begin
               ok = 1'b1;
               rval = {13'h0000, map_q, short_q, tdis_q};
            end else if (cmd_addr_i == RES_TUNE && cmd_wcnt_i == 8'h01) begin
               ok = 1'b1;
               rval = {13'h0000, tune_value_i}; // Raw value even when disabled.
            end
         end else if (cmd_bank_i == BANK_EPC) begin
            if (cmd_addr_i == EPC_CRC_WORD) begin
               ok = 1'b1;
               rval = epc_crc_o;
            end else if (epc_off <= {3'h0, epc_max}) begin
               ok = 1'b1;
               mem_rd = 1'b1;
               midx = epc_off[3:0];
            end
         end else if (cmd_bank_i == BANK_TID) begin
            if (cmd_addr_i < TID_WORDS) begin
               ok = 1'b1;
               case (cmd_addr_i[2:0])
                  3'h0: rval = {TID_WORD0[15:4], 1'b1, TID_WORD0[2:0]}; // Extended identity flag.
                  3'h1: rval = TID_MODEL;
                  3'h2: rval = TID_XHDR;
                  3'h3: rval = TID_SERIAL[47:32];
                  3'h4: rval = TID_SERIAL[31:16];
                  default: rval = TID_SERIAL[15:0];
               endcase
            end
         end else if (cmd_addr_i < user_max) begin
            ok = 1'b1;
            mem_rd = 1'b1;
            midx = user_idx[3:0];
         end
      end else if (is_wr) begin
         if (cmd_bank_i == BANK_RES) begin
            if (cmd_addr_i <= RES_ACC_LO && !res_locked_q) begin
               ok = 1'b1;
               pwd_wr = 1'b1;
            end else if (cmd_addr_i == RES_CFG && secured_q) begin
               ok = 1'b1;
               cfg_wr = 1'b1;
            end
         end else if (cmd_bank_i == BANK_EPC) begin
            if (cmd_addr_i == EPC_PC_WORD) begin
               // Length may move up or down but never past the map limit.
               ok = cmd_data_i[PC_LEN_MSB:PC_LEN_LSB] <= epc_max;
               mem_wr = ok;
               midx = MEM_PC;
            end else if (cmd_addr_i != EPC_CRC_WORD && epc_off <= {3'h0, epc_max}) begin
               ok = 1'b1;
               mem_wr = 1'b1;
               midx = epc_off[3:0];
            end
         end else if (cmd_bank_i == BANK_USER && cmd_addr_i < user_max) begin
            ok = 1'b1;
            mem_wr = 1'b1;
            midx = user_idx[3:0];
         end
      end else if (cmd_op_i == OP_LOCK) begin
         ok = 1'b1;
      end else if (cmd_op_i == OP_KILL) begin
         ok = (kill_pwd_q != PWD_RST) && (cmd_pwd_i == kill_pwd_q);
      end else if (cmd_op_i == OP_ACCESS) begin
         ok = (cmd_pwd_i == acc_pwd_q);
      end
   end

   // Word store port: the CRC walk owns the read address until idle.
   logic [3:0] idx_d;
   assign idx_d = (state_q == ST_INIT) ? 4'h0 : idx_q + 4'h1;
   assign mem.raddr = (state_q == ST_IDLE) ? midx : MEM_PC + idx_d;
   assign mem.we = take && mem_wr;
   assign mem.waddr = midx;
   assign mem.wdata = (midx == MEM_PC) ? (cmd_data_i | (16'h0001 << PC_UMI_BIT)) : cmd_data_i;

   // Length of the walk: read from the PC word and clamped to the store.
   logic [4:0] len_now;
   logic [4:0] len_pc;
   assign len_pc = mem.rdata[PC_LEN_MSB:PC_LEN_LSB];
   assign len_now = (idx_q == 4'h0) ? ((len_pc > EPC_MAX_MAP1) ? EPC_MAX_MAP1 : len_pc) : len_q;

   // Next state of the controller.
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_INIT: state_d = ST_CRC;
         ST_CRC: if ({1'b0, idx_q} == len_now) state_d = ST_IDLE;
         ST_IDLE: state_d = ST_IDLE;
         default: state_d = ST_INIT;
      endcase
   end

   // State register.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) state_q <= ST_INIT;
      else state_q <= state_d;
   end

   // Power-up CRC over PC and the EPC words that its length names.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         crc_q <= CRC_PRESET;
         idx_q <= 4'h0;
         len_q <= 5'h00;
      end else if (state_q == ST_INIT) begin
         crc_q <= CRC_PRESET;
         idx_q <= 4'h0;
      end else if (state_q == ST_CRC) begin
         crc_q <= crc_word(crc_q, mem.rdata);
         idx_q <= idx_d;
         len_q <= len_now;
      end
   end
   assign epc_crc_o = ~crc_q; // Stored CRC is the ones complement.

   // Passwords; reset value is the factory value of zero.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         kill_pwd_q <= PWD_RST;
         acc_pwd_q <= PWD_RST;
      end else if (take && pwd_wr) begin
         case (cmd_addr_i[1:0])
            2'h0: kill_pwd_q[31:16] <= cmd_data_i;
            2'h1: kill_pwd_q[15:0] <= cmd_data_i;
            2'h2: acc_pwd_q[31:16] <= cmd_data_i;
            default: acc_pwd_q[15:0] <= cmd_data_i;
         endcase
      end
   end

   // Configuration bits; other payload bits are dropped.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         map_q <= CFG_MAP_RST;
         short_q <= CFG_SHORT_RST;
         tdis_q <= CFG_TDIS_RST;
      end else if (take && cfg_wr) begin
         if (!map_locked_q) map_q <= cmd_data_i[CFG_MAP_BIT];
         short_q <= cmd_data_i[CFG_SHORT_BIT];
         if (!res_locked_q) tdis_q <= cmd_data_i[CFG_TDIS_BIT];
      end
   end

   // Lock state: the map freezes after one change or any accepted Lock.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         map_locked_q <= 1'b0;
         res_locked_q <= 1'b0;
      end else if (take && ok) begin
         if (cmd_op_i == OP_LOCK) begin
            map_locked_q <= 1'b1;
            if (cmd_data_i[0]) res_locked_q <= 1'b1;
         end else if (cfg_wr && cmd_data_i[CFG_MAP_BIT] != map_q) begin
            map_locked_q <= 1'b1;
         end
      end
   end

   // Secured and killed states. An access secures only with the matching password, zero included.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         secured_q <= 1'b0;
         killed_q <= 1'b0;
      end else if (take && ok) begin
         if (cmd_op_i == OP_ACCESS) secured_q <= 1'b1;
         if (cmd_op_i == OP_KILL) killed_q <= 1'b1;
      end
   end

   // Answer register: every accepted command answers on the next cycle.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rsp_valid_q <= 1'b0;
         rsp_ok_q <= 1'b0;
         rsp_mem_q <= 1'b0;
         rsp_val_q <= 16'h0000;
      end else begin
         rsp_valid_q <= take;
         rsp_ok_q <= take && ok;
         rsp_mem_q <= mem_rd;
         rsp_val_q <= (take && ok) ? rval : 16'h0000;
      end
   end

   // A killed tag never accepts another command.
   assign cmd_ready_o = (state_q == ST_IDLE) && !killed_q;
   assign rsp_valid_o = rsp_valid_q;
   assign rsp_ok_o = rsp_ok_q;
   assign rsp_data_o = (rsp_ok_q && rsp_mem_q) ? mem.rdata : rsp_val_q;
   assign secured_o = secured_q;
   assign killed_o = killed_q;
   assign short_range_o = short_q;
   assign mem_map_o = map_q;
   // Disabled tuning overrides the value with the no-change code.
   assign tune_code_o = tdis_q ? TUNE_MID : ((tune_value_i > TUNE_MAX) ? TUNE_MAX : tune_value_i);
   assign tune_ff_o = tune_ff(tune_code_o);

   // Longest power-up walk in cycles, kept local so the delay range sees a plain int.
   localparam int WALK_MAX = CRC_CYCLES_MAX;

   kill_zero_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (take && cmd_op_i == OP_KILL && kill_pwd_q == PWD_RST) |=> (!killed_o && !rsp_ok_o))
      else $error("kill accepted with zero password");
   cfg_unsec_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (take && !secured_q) |=> ($stable(short_q) && $stable(tdis_q) && $stable(map_q)))
      else $error("configuration changed while not secured");
   map_once_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      $changed(map_q) |-> ($past(!map_locked_q) && map_locked_q))
      else $error("memory map changed twice");
   lock_map_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (take && cmd_op_i == OP_LOCK) |=> map_locked_q ##1 map_locked_q)
      else $error("lock left memory map open");
   tune_off_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      tdis_q |-> (tune_code_o == TUNE_MID && tune_ff_o == 8'sd0))
      else $error("tuning not overridden");
   tune_read_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (take && cmd_op_i == OP_READ && cmd_bank_i == BANK_RES && cmd_addr_i == RES_TUNE && cmd_wcnt_i == 8'h01)
      |=> (rsp_ok_o && rsp_data_o == {13'h0000, $past(tune_value_i)}))
      else $error("tuning value read wrong");
   crc_walk_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (state_q == ST_INIT) |-> ##[1:WALK_MAX] (state_q == ST_IDLE))
      else $error("power-up CRC walk too long");
   access_pwd_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (take && cmd_op_i == OP_ACCESS && cmd_pwd_i != acc_pwd_q && !secured_q) |=> !secured_o)
      else $error("secured without password");
   res_lock_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      res_locked_q |=> $stable(tdis_q))
      else $error("tuning disable changed while locked");
endmodule : tmc_top
`default_nettype wire

// ===== pkg/tmc_mem_if.sv
// Interface between the controller and its word store.
// Assumes a single clock domain shared by both ends.
`default_nettype none
interface tmc_mem_if;
   import tmc_pkg::*;
   logic we; // Write strobe, one cycle.
   logic [MEM_AW-1:0] waddr; // Write word index.
   logic [15:0] wdata; // Write data.
   logic [MEM_AW-1:0] raddr; // Read word index, sampled every cycle.
   logic [15:0] rdata; // Registered read data.
   modport ctrl (output we, waddr, wdata, raddr, input rdata);
   modport store (input we, waddr, wdata, raddr, output rdata);
endinterface : tmc_mem_if
`default_nettype wire

// ===== pkg/tmc_pkg.sv
// Shared constants and types for the tag memory and configuration block.
// Assumes one 10 MHz clock and that the reader commands arrive already demodulated.
`default_nettype none
package tmc_pkg;
   // Command codes of the decoded air command.
   typedef enum logic [2:0] {
      OP_READ = 3'h0, OP_WRITE = 3'h1, OP_BWRITE = 3'h2, OP_LOCK = 3'h3, OP_KILL = 3'h4, OP_ACCESS = 3'h5
   } tmc_op_t;
   // Memory bank codes.
   localparam logic [1:0] BANK_RES = 2'h0;
   localparam logic [1:0] BANK_EPC = 2'h1;
   localparam logic [1:0] BANK_TID = 2'h2;
   localparam logic [1:0] BANK_USER = 2'h3;
   // Reserved bank word addresses.
   localparam logic [7:0] RES_KILL_HI = 8'h00;
   localparam logic [7:0] RES_ACC_LO = 8'h03;
   localparam logic [7:0] RES_CFG = 8'h04;
   localparam logic [7:0] RES_TUNE = 8'h0E;
   // Field positions in the configuration word.
   localparam int CFG_MAP_BIT = 2;
   localparam int CFG_SHORT_BIT = 1;
   localparam int CFG_TDIS_BIT = 0;
   // Values after reset (factory state).
   localparam logic CFG_MAP_RST = 1'b1;
   localparam logic CFG_SHORT_RST = 1'b0;
   localparam logic CFG_TDIS_RST = 1'b0;
   localparam logic [31:0] PWD_RST = 32'h0000_0000;
   localparam logic [15:0] PC_RST = 16'h3400;
   // EPC bank layout and protocol-control fields.
   localparam logic [7:0] EPC_CRC_WORD = 8'h00;
   localparam logic [7:0] EPC_PC_WORD = 8'h01;
   localparam int PC_LEN_MSB = 15;
   localparam int PC_LEN_LSB = 11;
   localparam int PC_UMI_BIT = 10;
   localparam logic [4:0] EPC_MAX_MAP1 = 5'h08;
   localparam logic [4:0] EPC_MAX_MAP0 = 5'h06;
   localparam logic [7:0] USER_WORDS_MAP1 = 8'h02;
   localparam logic [7:0] USER_WORDS_MAP0 = 8'h04;
   // Physical word store layout: PC, EPC words, user words.
   localparam int MEM_AW = 4;
   localparam logic [3:0] MEM_PC = 4'h0;
   localparam logic [3:0] MEM_USER = 4'h9;
   // CRC16 polynomial and preset.
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_PRESET = 16'hFFFF;
   // Tuning value handling; code two means no capacitance change.
   localparam logic [2:0] TUNE_MID = 3'h2;
   localparam logic [2:0] TUNE_MAX = 3'h4;
   // Read-only identification bank.
   localparam logic [7:0] TID_WORDS = 8'h06;
   localparam logic [15:0] TID_XHDR = 16'h2000;
   // Power-up CRC walk takes at most this many cycles.
   localparam int CRC_CYCLES_MAX = 11;
   // Controller states, Gray coded along init, crc, idle.
   typedef enum logic [1:0] {ST_INIT = 2'b00, ST_CRC = 2'b01, ST_IDLE = 2'b11} tmc_state_t;
endpackage : tmc_pkg
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the tag memory and configuration block.
// Assumes the reader model drives every command and the clock runs at 10 MHz.
`default_nettype none
module tb;
   import tmc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0; // Bench clock.
   logic arst_n = 1'b0; // Reset, active low.
   logic [2:0] tune_value = 3'h2; // Analog tuning input.
   logic ok; // Status of the last command.
   logic [15:0] rd; // Data of the last command.
   int failures = 0;
   int tests_run = 0;
   wire logic cmd_valid, cmd_ready, rsp_valid, rsp_ok, secured, killed, short_range, mem_map;
   wire tmc_op_t cmd_op;
   wire logic [1:0] cmd_bank;
   wire logic [7:0] cmd_addr, cmd_wcnt;
   wire logic [15:0] cmd_data, rsp_data, epc_crc;
   wire logic [31:0] cmd_pwd;
   wire logic [2:0] tune_code;
   wire logic signed [7:0] tune_ff;
   // Expected capacitance change per code: -80, -40, 0, +60, +100 fF.
   logic [7:0] ff_tab [5] = '{8'hB0, 8'hD8, 8'h00, 8'h3C, 8'h64};
   tmc_top dut_u (.mclk_i(mclk), .arst_n_i(arst_n), .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op),
      .cmd_bank_i(cmd_bank), .cmd_addr_i(cmd_addr), .cmd_wcnt_i(cmd_wcnt), .cmd_data_i(cmd_data),
      .cmd_pwd_i(cmd_pwd), .tune_value_i(tune_value), .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid),
      .rsp_ok_o(rsp_ok), .rsp_data_o(rsp_data), .secured_o(secured), .killed_o(killed),
      .short_range_o(short_range), .mem_map_o(mem_map), .tune_code_o(tune_code), .tune_ff_o(tune_ff),
      .epc_crc_o(epc_crc));
   tmc_reader reader_u (.mclk_i(mclk), .cmd_ready_i(cmd_ready), .rsp_valid_i(rsp_valid), .rsp_ok_i(rsp_ok),
      .rsp_data_i(rsp_data), .cmd_valid_o(cmd_valid), .cmd_op_o(cmd_op), .cmd_bank_o(cmd_bank),
      .cmd_addr_o(cmd_addr), .cmd_wcnt_o(cmd_wcnt), .cmd_data_o(cmd_data), .cmd_pwd_o(cmd_pwd));
   // Free-running clock, 100 ns period.
   initial begin
      forever #50 mclk = ~mclk;
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Reference CRC of the factory PC and its six blank EPC words, one bit at a time.
   function automatic logic [15:0] ref_crc();
      logic [15:0] c;
      logic [111:0] s;
      c = CRC_PRESET;
      s = {PC_RST, 96'h0};
      for (int i = 111; i >= 0; i--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ s[i]) ? CRC_POLY : 16'h0000);
      end
      return ~c;
   endfunction : ref_crc
   // Short form of a reader command; word count defaults to one.
   task automatic cmd(input tmc_op_t op, input logic [1:0] bk, input logic [7:0] a, input logic [15:0] d,
                      input logic [31:0] p = 32'h0000_0000, input logic [7:0] n = 8'h01);
      reader_u.issue(op, bk, a, n, d, p, ok, rd);
   endtask : cmd
   task automatic test_reset;
      cmd(OP_READ, BANK_EPC, EPC_PC_WORD, 16'h0000);
      check("pc", rd, 16'h3400);
      check("crc", epc_crc, ref_crc());
      cmd(OP_READ, BANK_EPC, EPC_CRC_WORD, 16'h0000);
      check("crcrd", rd, ref_crc());
      cmd(OP_READ, BANK_TID, 8'h00, 16'h0000);
      check("tidx", rd[3], 1'b1);
      cmd(OP_READ, BANK_TID, 8'h02, 16'h0000);
      check("xhdr", rd, TID_XHDR);
      cmd(OP_READ, BANK_RES, RES_ACC_LO, 16'h0000);
      check("acc", rd, 16'h0000);
      check("map", mem_map, 1'b1);
      check("short", short_range, 1'b0);
      $display("test reset done");
   endtask : test_reset
   task automatic test_refuse;
      cmd(OP_KILL, BANK_RES, RES_KILL_HI, 16'h0000);
      check("kill0", ok, 1'b0);
      cmd(OP_ACCESS, BANK_RES, 8'h00, 16'h0000, 32'h0000_0001);
      check("acc1", secured, 1'b0);
      cmd(OP_WRITE, BANK_RES, RES_CFG, 16'h0002);
      check("cfgok", ok, 1'b0);
      check("short", short_range, 1'b0);
      $display("test refuse done");
   endtask : test_refuse
   task automatic test_config;
      cmd(OP_ACCESS, BANK_RES, 8'h00, 16'h0000);
      check("sec", secured, 1'b1);
      cmd(OP_BWRITE, BANK_RES, RES_CFG, 16'hFFFA, 32'h0000_0000, 8'h02);
      check("bw2", ok, 1'b0);
      cmd(OP_WRITE, BANK_RES, RES_CFG, 16'hFFFA);
      check("map", mem_map, 1'b0);
      check("short", short_range, 1'b1);
      cmd(OP_BWRITE, BANK_RES, RES_CFG, 16'h0004);
      check("maplk", mem_map, 1'b0);
      check("short", short_range, 1'b0);
      cmd(OP_WRITE, BANK_EPC, EPC_PC_WORD, 16'h3C00);
      check("len7", ok, 1'b0);
      cmd(OP_WRITE, BANK_EPC, EPC_PC_WORD, 16'h2800);
      cmd(OP_READ, BANK_EPC, EPC_PC_WORD, 16'h0000);
      check("pc5", rd, 16'h2C00);
      cmd(OP_WRITE, BANK_USER, 8'h03, 16'hBEEF);
      cmd(OP_READ, BANK_USER, 8'h03, 16'h0000);
      check("user3", rd, 16'hBEEF);
      $display("test config done");
   endtask : test_config
   task automatic test_tune;
      for (int i = 0; i < 5; i++) begin
         tune_value = 3'(i);
         cmd(OP_READ, BANK_RES, RES_TUNE, 16'h0000);
         check("tval", rd, 16'(i));
         check("tcode", tune_code, 16'(i));
         check("tff", tune_ff, {{8{ff_tab[i][7]}}, ff_tab[i]});
      end
      cmd(OP_WRITE, BANK_RES, RES_TUNE, 16'h0001);
      check("twr", ok, 1'b0);
      cmd(OP_WRITE, BANK_RES, RES_CFG, 16'h0001);
      check("tdis", tune_code, TUNE_MID);
      check("tff0", tune_ff, 16'h0000);
      cmd(OP_READ, BANK_RES, RES_TUNE, 16'h0000);
      check("traw", rd, 16'h0004);
      $display("test tune done");
   endtask : test_tune
   task automatic test_lock_kill;
      cmd(OP_WRITE, BANK_RES, RES_KILL_HI, 16'h1234);
      cmd(OP_WRITE, BANK_RES, 8'h01, 16'h5678);
      cmd(OP_LOCK, BANK_RES, 8'h00, 16'h0001);
      cmd(OP_WRITE, BANK_RES, RES_CFG, 16'h0000);
      check("tlock", tune_code, TUNE_MID);
      cmd(OP_KILL, BANK_RES, 8'h00, 16'h0000, 32'h1234_5679);
      check("kbad", killed, 1'b0);
      cmd(OP_KILL, BANK_RES, 8'h00, 16'h0000, 32'h1234_5678);
      check("kill", killed, 1'b1);
      check("mute", cmd_ready, 1'b0);
      $display("test lock and kill done");
   endtask : test_lock_kill
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict
   // Main sequence after a 12-cycle reset.
   initial begin
      repeat (12) @(posedge mclk);
      #5 arst_n = 1'b1;
      test_reset();
      test_refuse();
      test_config();
      test_tune();
      test_lock_kill();
      give_verdict();
   end
   // Watchdog: the tests need well under 500 cycles, so 20000 means a hang.
   initial begin
      #2_000_000;
      failures++;
      give_verdict();
   end
endmodule : tb
`default_nettype wire

// ===== tb/tmc_reader.sv
// Reader model: issues decoded air commands to the tag block, one at a time.
// Assumes one shared clock and that the bench calls issue only after reset.
`default_nettype none
module tmc_reader
   import tmc_pkg::*;
(
   input wire logic mclk_i,
   input wire logic cmd_ready_i,
   input wire logic rsp_valid_i,
   input wire logic rsp_ok_i,
   input wire logic [15:0] rsp_data_i,
   output logic cmd_valid_o,
   output tmc_op_t cmd_op_o,
   output logic [1:0] cmd_bank_o,
   output logic [7:0] cmd_addr_o,
   output logic [7:0] cmd_wcnt_o,
   output logic [15:0] cmd_data_o,
   output logic [31:0] cmd_pwd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle lines start defined so the block never samples unknowns.
   initial begin
      {cmd_valid_o, cmd_bank_o, cmd_addr_o, cmd_wcnt_o, cmd_data_o, cmd_pwd_o} = '0;
      cmd_op_o = OP_READ;
   end
   // One command: held from just after an edge until the take edge.
   task automatic issue(input tmc_op_t op, input logic [1:0] bk, input logic [7:0] a, input logic [7:0] n,
                        input logic [15:0] d, input logic [31:0] p, output logic ok, output logic [15:0] rd);
      int w;
      w = 0;
      @(posedge mclk_i);
      #5;
      {cmd_op_o, cmd_bank_o, cmd_addr_o, cmd_wcnt_o, cmd_data_o, cmd_pwd_o} = {op, bk, a, n, d, p};
      cmd_valid_o = 1'b1;
      while (cmd_ready_i !== 1'b1 && w < 50) begin
         @(posedge mclk_i);
         #5;
         w++;
      end
      // A tag that never becomes ready is a failure of the run, not a quiet refusal.
      if (w >= 50) tb.failures++;
      @(posedge mclk_i);
      #5;
      // Released data and password lines show the inverse, so a late sample is never lucky.
      cmd_valid_o = 1'b0;
      cmd_data_o = ~d;
      cmd_pwd_o = ~p;
      ok = rsp_valid_i & rsp_ok_i;
      rd = rsp_data_i;
   endtask : issue
endmodule : tmc_reader
`default_nettype wire
